// ### gpio_regs.svh
// Register offsets, field positions and reset values of the port block
// How it works
// - Six-line port, each line input or output
// - Eight-line port, each line input or output
// - Direction one drives, zero reads pin
// - Reset clears both direction registers
// - Output line reads back its latch
// - Write updates latch, drives when output
// - Input line reads the pin level
// - Six-line data 0000, direction 0004
// - Eight-line data 0002, direction 0006
// - Reset leaves output latches unchanged
// - Unused six-line upper bits read zero
// - Optional low-level line interrupt, ORed
// - Optional capture feed from line 0
// - Compare option: line 1 latch never driven
// - Compare line reads timer compare or latch by direction
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define SIX_DATA_OFS    16'h0000
`define EIGHT_DATA_OFS  16'h0002
`define SIX_DIR_OFS     16'h0004
`define EIGHT_DIR_OFS   16'h0006
`define INT_STATUS_OFS  16'h0008
`define INT_MASK_OFS    16'h000A
`define DIR_RESET       8'h00
`define MASK_RESET      8'h00
`define STATUS_RESET    8'h00
`define STATUS_EXT_BIT  0
`define STATUS_CAP_BIT  1
`endif

// ### gpio_pkg.sv
// Types shared by the port block
package gpio_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] addr_t;
endpackage

// ### dual_parallel_io_ports.sv
// Two parallel I/O ports with register access and event interrupt
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpio_regs.svh"
module dual_parallel_io_ports
  import gpio_pkg::*;
#(
  parameter int        SIX_WIDTH   = 6,
  parameter logic [5:0] IRQ_OPTION = 6'h00,
  parameter bit        CAP_OPTION  = 1'b0,
  parameter bit        CMP_OPTION  = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire addr_t       addr,
  input  wire byte_t       wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output byte_t            rdData,
  input  wire logic [5:0]  sixLinePortPinsIn,
  output logic [5:0]       sixLinePortPinsOut,
  output logic [5:0]       sixLinePortPinsOeN,
  input  wire logic [7:0]  eightLinePortPinsIn,
  output logic [7:0]       eightLinePortPinsOut,
  output logic [7:0]       eightLinePortPinsOeN,
  input  wire logic        irqPinN,
  input  wire logic        timerCompareOutput,
  output logic             timerCaptureInput,
  output logic             extIrqRequest,
  output logic             irqOut
);

  byte_t       sixLatch_reg;
  byte_t       eightLatch_reg;
  byte_t       sixDir_reg;
  byte_t       eightDir_reg;
  byte_t       status_reg;
  byte_t       mask_reg;
  logic [5:0]  sixMeta_reg;
  logic [5:0]  sixSync_reg;
  logic [7:0]  eightMeta_reg;
  logic [7:0]  eightSync_reg;
  logic        irqMeta_reg;
  logic        irqSync_reg;
  logic        cmpMeta_reg;
  logic        cmpSync_reg;
  logic        extReqPrev_reg;
  logic        capPrev_reg;
  logic [5:0]  sixRead;
  logic [7:0]  eightRead;
  logic        extReq_next;
  logic        cap_next;
  byte_t       rdData_next;
  byte_t       status_next;

  // Two-stage synchronisers on every pin before any logic looks at it
  always_ff @(posedge sys_clk) begin
    sixMeta_reg   <= sixLinePortPinsIn;
    sixSync_reg   <= sixMeta_reg;
    eightMeta_reg <= eightLinePortPinsIn;
    eightSync_reg <= eightMeta_reg;
    irqMeta_reg   <= irqPinN;
    irqSync_reg   <= irqMeta_reg;
    cmpMeta_reg   <= timerCompareOutput;
    cmpSync_reg   <= cmpMeta_reg;
  end

  // Output latches have no reset so software state survives a pin reset
  // latches not reset
  always_ff @(posedge sys_clk) begin
    if (wrStrobe && addr == `SIX_DATA_OFS) begin
      sixLatch_reg <= {2'b00, wrData[5:0]};
    end
    if (wrStrobe && addr == `EIGHT_DATA_OFS) begin
      eightLatch_reg <= wrData;
    end
  end

  // Direction registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sixDir_reg   <= `DIR_RESET;
      eightDir_reg <= `DIR_RESET;
    end else begin
      if (wrStrobe && addr == `SIX_DIR_OFS) begin
        sixDir_reg <= {2'b00, wrData[5:0]};
      end
      if (wrStrobe && addr == `EIGHT_DIR_OFS) begin
        eightDir_reg <= wrData;
      end
    end
  end

  // Pin drivers; enable is active low, no drive while latch is unknown
  // matters only once direction is set, which software does after writing
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sixLinePortPinsOut   <= 6'h00;
      sixLinePortPinsOeN   <= 6'h3F;
      eightLinePortPinsOut <= 8'h00;
      eightLinePortPinsOeN <= 8'hFF;
    end else begin
      sixLinePortPinsOut   <= sixLatch_reg[5:0];
      sixLinePortPinsOeN   <= ~sixDir_reg[5:0];
      eightLinePortPinsOut <= eightLatch_reg;
      eightLinePortPinsOeN <= ~eightDir_reg;
      if (CMP_OPTION) begin
        eightLinePortPinsOut[1] <= cmpSync_reg;
        eightLinePortPinsOeN[1] <= 1'b0;
      end
    end
  end

  // Read-back mux per line
  // output reads latch
  always_comb begin
    sixRead   = (sixDir_reg[5:0] & sixLatch_reg[5:0])
              | (~sixDir_reg[5:0] & sixSync_reg);
    eightRead = (eightDir_reg & eightLatch_reg)
              | (~eightDir_reg & eightSync_reg);
    if (CMP_OPTION) begin
      eightRead[1] = eightDir_reg[1] ? eightLatch_reg[1] : cmpSync_reg;
    end
  end

  // Address decode for reads; unmapped offsets answer zero
  always_comb begin
    rdData_next = 8'h00;
    case (addr)
      `SIX_DATA_OFS:   rdData_next = {2'b00, sixRead};
      `SIX_DIR_OFS:    rdData_next = {2'b00, sixDir_reg[5:0]};
      `EIGHT_DATA_OFS: rdData_next = eightRead;
      `EIGHT_DIR_OFS:  rdData_next = eightDir_reg;
      `INT_STATUS_OFS: rdData_next = status_reg;
      `INT_MASK_OFS:   rdData_next = mask_reg;
      default:         rdData_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdStrobe ? rdData_next : 8'h00;
    end
  end

  // External request: dedicated pin or any optioned six-line line reading low (pin if input, latch if output)
  // level request ORed
  always_comb begin
    extReq_next = ~irqSync_reg
                | (|(IRQ_OPTION & ~sixRead));
    cap_next = CAP_OPTION ? eightRead[0] : 1'b0;
  end

  // Request and capture outputs registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      extIrqRequest     <= 1'b0;
      timerCaptureInput <= 1'b0;
      // Track live levels in reset so a line that is already low or high
      // when reset lifts does not raise a false edge event
      extReqPrev_reg    <= extReq_next;
      capPrev_reg       <= cap_next;
    end else begin
      extIrqRequest     <= extReq_next;
      timerCaptureInput <= cap_next;
      extReqPrev_reg    <= extReq_next;
      capPrev_reg       <= cap_next;
    end
  end

  // Sticky status: request rise and capture edge; a set beats a clear
  always_comb begin
    status_next = status_reg;
    if (wrStrobe && addr == `INT_STATUS_OFS) begin
      status_next = status_reg & ~wrData;
    end
    if (extReq_next && !extReqPrev_reg) begin
      status_next[`STATUS_EXT_BIT] = 1'b1;
    end
    if (cap_next != capPrev_reg) begin
      status_next[`STATUS_CAP_BIT] = 1'b1;
    end
    status_next[7:2] = 6'h00;
  end

  // Status, mask and the level interrupt line
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_reg <= `STATUS_RESET;
      mask_reg   <= `MASK_RESET;
      irqOut     <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (wrStrobe && addr == `INT_MASK_OFS) begin
        mask_reg <= {6'h00, wrData[1:0]};
      end
      irqOut <= |(status_next & mask_reg);
    end
  end

endmodule

// ### io_ports_sva.sv
// Checker for bus and pin relations of the port block
`timescale 1ns/1ps
module io_ports_sva
  import gpio_pkg::*;
#(
  parameter bit CMP_OPTION = 1'b0
) (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire addr_t      addr,
  input wire byte_t      wrData,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire byte_t      rdData,
  input wire logic [5:0] sixLinePortPinsOeN,
  input wire logic [7:0] eightLinePortPinsOut,
  input wire logic [7:0] eightLinePortPinsOeN,
  input wire logic       irqPinN,
  input wire logic       timerCompareOutput,
  input wire logic       extIrqRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Direction write to the eight-line port, then its pins 7 to 2 two edges on
  sequence s_dir8;
    wrStrobe && addr == 16'h0006;
  endsequence
  property p_rd_idle;
    !$past(rdStrobe) |-> rdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdData not idle");
  property p_oe_rst;
    disable iff (1'b0) !resetn |=> &sixLinePortPinsOeN && &eightLinePortPinsOeN;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("oe on reset");
  property p_dir8;
    s_dir8 |-> ##2 eightLinePortPinsOeN[7:2] == ~$past(wrData[7:2], 2);
  endproperty
  a_dir8: assert property (p_dir8) else $error("eight oe");
  property p_dir6;
    wrStrobe && addr == 16'h0004 |-> ##2
      sixLinePortPinsOeN == ~$past(wrData[5:0], 2);
  endproperty
  a_dir6: assert property (p_dir6) else $error("six oe");
  property p_six_hi;
    $past(rdStrobe && addr[15:3] == 13'h0000 && !addr[1]) |-> !rdData[7:6];
  endproperty
  a_six_hi: assert property (p_six_hi) else $error("six upper");
  property p_unmap;
    $past(rdStrobe && addr > 16'h000A) |-> rdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Compare line carries the timer level, never the latch
  property p_cmp;
    (CMP_OPTION && $stable(timerCompareOutput)) [*6] |->
      eightLinePortPinsOut[1] == timerCompareOutput;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare pin");
  property p_ext_lo;
    (!irqPinN) [*5] |-> extIrqRequest;
  endproperty
  a_ext_lo: assert property (p_ext_lo) else $error("ext request");
endmodule
bind dual_parallel_io_ports io_ports_sva #(.CMP_OPTION(CMP_OPTION)) u_sva (.*);

// ### port_pins_model.sv
// Pins and outside loads of both ports
`timescale 1ns/1ps
module port_pins_model (
  input  wire logic [5:0] sixLinePortPinsOut,
  input  wire logic [5:0] sixLinePortPinsOeN,
  input  wire logic [5:0] sixExt,
  input  wire logic [7:0] eightLinePortPinsOut,
  input  wire logic [7:0] eightLinePortPinsOeN,
  input  wire logic [7:0] eightExt,
  input  wire logic       heavyLoad,
  output logic      [5:0] sixLinePortPinsIn,
  output logic      [7:0] eightLinePortPinsIn
);
  // Released lines follow the outside source, as a pull-up would
  assign sixLinePortPinsIn = ~sixLinePortPinsOeN & sixLinePortPinsOut
                           | sixLinePortPinsOeN & sixExt;
  // A heavy load beats the driver, so a pin read would differ from the latch
  assign eightLinePortPinsIn = heavyLoad ? eightExt
                             : ~eightLinePortPinsOeN & eightLinePortPinsOut
                             | eightLinePortPinsOeN & eightExt;
endmodule

// ### tb_dual_parallel_io_ports.sv
// Self-checking bench for the two parallel ports
`timescale 1ns/1ps
module tb_dual_parallel_io_ports;
  import gpio_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0;
  logic irqPinN = 1'b1, timerCompareOutput = 1'b0, heavyLoad = 1'b0;
  logic rdLate = 1'b0, timerCaptureInput, extIrqRequest, irqOut;
  addr_t addr = 16'h0000;
  byte_t wrData = 8'h00, eightExt = 8'hFF, rdData, v, w, d, q[$];
  byte_t eightLinePortPinsIn, eightLinePortPinsOut, eightLinePortPinsOeN;
  logic [5:0] sixExt = 6'h3F, sixLinePortPinsIn, sixLinePortPinsOut;
  logic [5:0] sixLinePortPinsOeN;
  logic [31:0] seed = 32'h0001548B;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  dual_parallel_io_ports #(.IRQ_OPTION(6'h3F), .CAP_OPTION(1'b1),
    .CMP_OPTION(1'b1)) u_dut (.*);
  port_pins_model u_pins (.*);
  initial forever #5 sys_clk = ~sys_clk;
  function automatic byte_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(string name, byte_t seen, byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic reset();
    resetn <= 1'b0;
    idle(16);
    resetn <= 1'b1;
  endtask
  // Bus cycles; a read notes its expected data for the monitor
  task automatic wr(addr_t a, byte_t dt);
    @(posedge sys_clk);
    addr <= a; wrData <= dt; wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(addr_t a, byte_t e);
    @(posedge sys_clk);
    addr <= a; rdStrobe <= 1'b1; q.push_back(e);
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
  endtask
  // Read data stand one cycle after the strobe; a hang ends the run
  always @(posedge sys_clk) begin
    if (rdLate) check("rdData", rdData, q.pop_front());
    rdLate <= rdStrobe;
    cycles++;
    if (cycles == 3000) begin num_errors++; close_out(); end
  end
  initial begin
    reset();
    rd(16'h0004, 8'h00);
    rd(16'h0006, 8'h00);
    v = xs(); w = xs(); eightExt <= xs(); sixExt <= w[5:0];
    wr(16'h0002, v);
    idle(4);
    rd(16'h0002, {eightExt[7:2], 1'b0, eightExt[0]});
    rd(16'h0000, {2'b00, sixExt});
    heavyLoad <= 1'b1; eightExt <= ~v;
    wr(16'h0006, 8'hFF);
    idle(4);
    rd(16'h0002, v);
    check("oe", eightLinePortPinsOeN, 8'h00);
    check("out", eightLinePortPinsOut, {v[7:2], 1'b0, v[0]});
    for (int i = 0; i < 4; i++) begin
      w = xs(); d = xs();
      wr(16'h0000, w);
      wr(16'h0004, d);
      idle(4);
      rd(16'h0000, {2'b00, w[5:0] & d[5:0] | sixExt & ~d[5:0]});
      rd(16'h0004, {2'b00, d[5:0]});
    end
    heavyLoad <= 1'b0; timerCompareOutput <= 1'b1;
    wr(16'h0006, 8'hFD);
    idle(6);
    rd(16'h0002, {v[7:2], 1'b1, v[0]});
    reset();
    wr(16'h0006, 8'hFF);
    wr(16'h0004, 8'h3F);
    idle(4);
    rd(16'h0002, v);
    rd(16'h0000, {2'b00, w[5:0]});
    check("six out", {2'b00, sixLinePortPinsOut}, {2'b00, w[5:0]});
    wr(16'h0020, 8'hFF);
    rd(16'h0020, 8'h00);
    sixExt <= 6'h3F;
    wr(16'h0000, 8'h3F);
    idle(6);
    wr(16'h0008, 8'h03);
    wr(16'h000A, 8'h01);
    irqPinN <= 1'b0;
    idle(8);
    irqPinN <= 1'b1;
    idle(8);
    check("irq", {7'h00, irqOut}, 8'h01);
    rd(16'h0008, 8'h01);
    wr(16'h0008, 8'h01);
    idle(3);
    check("irq", {7'h00, irqOut}, 8'h00);
    wr(16'h000A, 8'h00);
    wr(16'h0004, 8'h00);
    sixExt <= 6'h3E;
    idle(8);
    check("req", {7'h00, extIrqRequest}, 8'h01);
    check("irq", {7'h00, irqOut}, 8'h00);
    sixExt <= 6'h3F;
    wr(16'h0002, 8'h00);
    idle(4);
    wr(16'h0008, 8'h03);
    wr(16'h0002, 8'h01);
    idle(4);
    check("cap", {7'h00, timerCaptureInput}, 8'h01);
    rd(16'h0008, 8'h02);
    close_out();
  end
endmodule
